// ===== inc/clk_ctrl_pkg.sv
package clk_ctrl_pkg;

  // register indices; the byte address on the bus is four times the index
  localparam logic [31:0] IDX_CLOCK_SETUP = 32'h0000_4000;
  localparam logic [31:0] IDX_CORE_SUPPLY = 32'h0000_4001;
  localparam logic [31:0] IDX_PLL_PARAMS = 32'h0000_4002;
  localparam logic [31:0] ADDR_CLOCK_SETUP = IDX_CLOCK_SETUP << 2;
  localparam logic [31:0] ADDR_CORE_SUPPLY = IDX_CORE_SUPPLY << 2;
  localparam logic [31:0] ADDR_PLL_LO = IDX_PLL_PARAMS << 2;
  localparam logic [31:0] ADDR_PLL_HI = ADDR_PLL_LO + 32'h0000_0004;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'h0001_0020;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h0001_0024;

  // clock_setup fields
  localparam int CS_CORE_EN = 0;
  localparam int CS_IN_FREQ_LSB = 1;
  localparam int CS_SRC_SEL = 3;
  localparam int CS_OUT_EN = 4;
  localparam int CS_OUT_FREQ_LSB = 5;
  localparam logic [7:0] CS_RESET = 8'h00;
  localparam logic [7:0] CS_WMASK = 8'h7f;
  localparam logic [1:0] IN_FREQ_1024 = 2'b11;

  // core_supply_level fields
  localparam int SUP_LVL_LSB = 1;
  localparam logic [7:0] SUP_RESET = 8'h02;
  localparam logic [7:0] SUP_WMASK = 8'h06;

  // pll_parameters fields
  localparam int PLL_EN = 0;
  localparam int PLL_LOCK = 1;
  localparam int PLL_TYPE = 8;
  localparam int PLL_XDIV_LSB = 9;
  localparam int PLL_INT_LSB = 11;
  localparam int PLL_NUM_LSB = 16;
  localparam int PLL_DEN_LSB = 32;
  localparam logic [47:0] PLL_RESET = 48'h0753_0287_1901;
  localparam logic [47:0] PLL_WMASK = 48'hffff_ffff_7f01;

  // interrupt status bits
  localparam int IRQ_LOCK = 0;
  localparam int IRQ_SRC_MISMATCH = 1;
  localparam int IRQ_W = 2;

  // divided-input ticks seen before the pll reports lock
  localparam logic [15:0] LOCK_TICKS = 16'h0400;
  // clock output half period in reference ticks at the 256x setting
  localparam logic [4:0] CLKOUT_HALF_BASE = 5'h02;
  localparam logic [4:0] ONE5 = 5'h01;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ===== src/tick_divider.sv
`timescale 1ns/100ps
module tick_divider #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // ticks in, divided ticks out
  input wire logic tick_in,
  input wire logic [W-1:0] last,
  output logic tick_out
);

  logic [W-1:0] count_q;

  // >= keeps the count sane when last is lowered mid-count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= '0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if (count_q >= last) begin
          count_q <= '0;
          tick_out <= 1'b1;
        end else begin
          count_q <= count_q + 1'b1;
        end
      end
    end
  end

endmodule // tick_divider

// ===== src/codec_clock_control.sv
`timescale 1ns/100ps
// Summary of operation
// [RULE1] all control registers except pll_parameters are byte wide, read and write
// [RULE2] pll_parameters is 48 bits, committed whole by one two-word write
// [RULE3] clock_setup at 0x4000, core_supply_level 0x4001, pll_parameters from 0x4002
// [RULE4] clock_setup [6:5] picks clock output at 32, 64, 128, 256 fs
// [RULE5] clock_setup bit 4 enables clock output pin, reset disabled
// [RULE6] clock_setup bit 3 picks master clock pin or pll, reset pin
// [RULE7] pll output is 1024 fs; software must declare input as 11
// [RULE8] clock_setup [2:1] declares input as 256, 512, 768, 1024 fs
// [RULE9] divider divides source by 1 to 4 so core gets 256 fs
// [RULE10] external source gives exact multiple, at most 1024 times 48 kHz
// [RULE11] clock_setup bit 0 gates core clock, reset off
// [RULE12] core_supply_level [2:1] sets core supply, 1.4 V after reset
// [RULE13] software should pick 1.5 V while configuring the processing core
// [RULE14] pll scales master clock, integer-N and fractional modes
// [RULE15] pll bit 8 picks fractional or integer-N, bit 0 enables pll
// [RULE16] pll bit 1 is read-only sticky lock indication
// [RULE17] pll multiplies input/X by R plus N over M
// [RULE18] clock output is 1024 fs reference divided by 32, 16, 8, 4
module codec_clock_control (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // clock pins and core controls
  input wire logic master_clock_input_pin,
  output logic clock_output_pin,
  output logic core_clock_tick,
  output logic [1:0] core_supply_output,
  // interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  localparam int IRQ_W = clk_ctrl_pkg::IRQ_W;
  logic [7:0] cs_q;
  logic [7:0] sup_q;
  logic [47:0] pll_q;
  logic [31:0] stage_lo_q;
  logic lock_q;
  logic [IRQ_W-1:0] status_q;
  logic [IRQ_W-1:0] mask_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_held_q;
  logic w_held_q;
  logic do_write;
  logic hit_cs, hit_sup, hit_lo, hit_hi, hit_st, hit_mk, hit_any;
  logic pll_commit;
  logic [31:0] rdata_d;
  logic rhit;

  assign do_write = aw_held_q & w_held_q & ~bvalid;
  assign hit_cs = awaddr_q == clk_ctrl_pkg::ADDR_CLOCK_SETUP; // RULE3
  assign hit_sup = awaddr_q == clk_ctrl_pkg::ADDR_CORE_SUPPLY; // RULE3
  assign hit_lo = awaddr_q == clk_ctrl_pkg::ADDR_PLL_LO; // RULE3
  assign hit_hi = awaddr_q == clk_ctrl_pkg::ADDR_PLL_HI;
  assign hit_st = awaddr_q == clk_ctrl_pkg::ADDR_IRQ_STATUS;
  assign hit_mk = awaddr_q == clk_ctrl_pkg::ADDR_IRQ_MASK;
  assign hit_any = hit_cs | hit_sup | hit_lo | hit_hi | hit_st | hit_mk;
  assign pll_commit = do_write & hit_hi;

  ////////////////////////////////////////////////////////////////////////////
  // write channels: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= clk_ctrl_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awaddr_q <= awaddr;
        aw_held_q <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
        w_held_q <= 1'b1;
        wready <= 1'b0;
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= hit_any ? clk_ctrl_pkg::RESP_OKAY : clk_ctrl_pkg::RESP_SLVERR; // RULE3
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte registers; upper lanes of these words are ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_q <= clk_ctrl_pkg::CS_RESET;
      sup_q <= clk_ctrl_pkg::SUP_RESET; // RULE12
    end else if (do_write && wstrb_q[0]) begin
      if (hit_cs) cs_q <= wdata_q[7:0] & clk_ctrl_pkg::CS_WMASK; // RULE1
      if (hit_sup) sup_q <= wdata_q[7:0] & clk_ctrl_pkg::SUP_WMASK; // RULE1
    end
  end

  // low word waits in a stage so the 48 bits change in one step
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage_lo_q <= clk_ctrl_pkg::PLL_RESET[31:0];
      pll_q <= clk_ctrl_pkg::PLL_RESET;
    end else begin
      if (do_write && hit_lo) begin
        for (int b = 0; b < 4; b++) begin
          if (wstrb_q[b]) stage_lo_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
        end
      end
      if (pll_commit) pll_q <= {wdata_q[15:0], stage_lo_q} & clk_ctrl_pkg::PLL_WMASK; // RULE2
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel
  always_comb begin
    rhit = 1'b1;
    rdata_d = 32'h0000_0000;
    unique case (araddr)
      clk_ctrl_pkg::ADDR_CLOCK_SETUP: rdata_d[7:0] = cs_q; // RULE1
      clk_ctrl_pkg::ADDR_CORE_SUPPLY: rdata_d[7:0] = sup_q;
      clk_ctrl_pkg::ADDR_PLL_LO: begin
        rdata_d = pll_q[31:0];
        rdata_d[clk_ctrl_pkg::PLL_LOCK] = lock_q; // RULE16
      end
      clk_ctrl_pkg::ADDR_PLL_HI: rdata_d[15:0] = pll_q[47:32];
      clk_ctrl_pkg::ADDR_IRQ_STATUS: rdata_d[IRQ_W-1:0] = status_q;
      clk_ctrl_pkg::ADDR_IRQ_MASK: rdata_d[IRQ_W-1:0] = mask_q;
      default: rhit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= clk_ctrl_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rdata_d;
      rresp <= rhit ? clk_ctrl_pkg::RESP_OKAY : clk_ctrl_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // master clock pin is sampled; a rising level is one source tick
  logic mclk_prev_q;
  logic mclk_tick;
  logic pll_en, pll_frac;
  logic [15:0] pll_num, pll_den;
  logic [3:0] pll_int;
  logic [1:0] pll_xdiv;
  logic pll_in_tick;
  logic [23:0] acc_q;
  logic [23:0] step, unit;
  logic pll_emit;
  logic pll_tick_q;
  logic [15:0] lock_cnt_q;
  logic lock_event;

  assign mclk_tick = master_clock_input_pin & ~mclk_prev_q;
  assign pll_en = pll_q[clk_ctrl_pkg::PLL_EN]; // RULE15
  assign pll_frac = pll_q[clk_ctrl_pkg::PLL_TYPE]; // RULE15
  assign pll_xdiv = pll_q[clk_ctrl_pkg::PLL_XDIV_LSB +: 2];
  assign pll_int = pll_q[clk_ctrl_pkg::PLL_INT_LSB +: 4];
  assign pll_num = pll_q[clk_ctrl_pkg::PLL_NUM_LSB +: 16];
  assign pll_den = pll_q[clk_ctrl_pkg::PLL_DEN_LSB +: 16];

  always_ff @(posedge aclk) begin
    if (!aresetn) mclk_prev_q <= 1'b0;
    else mclk_prev_q <= master_clock_input_pin;
  end

  // pll input divider by 1 to 4
  tick_divider #(.W(2)) u_pll_xdiv (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick_in(mclk_tick & pll_en),
    .last(pll_xdiv), // RULE17
    .tick_out(pll_in_tick)
  );

  // phase accumulator in units of M; integer-N ignores the fraction.
  // a zero denominator falls back to integer-N rather than running away
  always_comb begin
    if (pll_frac && pll_den != 16'h0000) begin
      unit = {8'h00, pll_den};
      step = {20'h0_0000, pll_int} * {8'h00, pll_den} + {8'h00, pll_num}; // RULE17
    end else begin
      unit = 24'h00_0001;
      step = {20'h0_0000, pll_int}; // RULE14
    end
  end

  assign pll_emit = acc_q >= unit;

  // limitation: at most one pll tick per aclk, so the ratio must suit 250 MHz
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_q <= 24'h00_0000;
      pll_tick_q <= 1'b0;
    end else if (!pll_en || pll_commit) begin
      acc_q <= 24'h00_0000;
      pll_tick_q <= 1'b0;
    end else begin
      acc_q <= acc_q + (pll_in_tick ? step : 24'h00_0000) - (pll_emit ? unit : 24'h00_0000);
      pll_tick_q <= pll_emit; // RULE14
    end
  end

  // lock after a run of input ticks; new parameters start it over
  assign lock_event = pll_in_tick && lock_cnt_q == clk_ctrl_pkg::LOCK_TICKS - 16'h0001;

  always_ff @(posedge aclk) begin
    if (!aresetn || !pll_en || pll_commit) lock_cnt_q <= 16'h0000;
    else if (pll_in_tick && lock_cnt_q != clk_ctrl_pkg::LOCK_TICKS) lock_cnt_q <= lock_cnt_q + 16'h0001;
  end

  // sticky; a lock in the commit cycle wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) lock_q <= 1'b0;
    else if (lock_event) lock_q <= 1'b1; // RULE16
    else if (pll_commit) lock_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // source select, core divider and clock output
  logic src_tick;
  logic core_tick;
  logic out_tick;
  logic [3:0] out_last;

  assign src_tick = cs_q[clk_ctrl_pkg::CS_SRC_SEL] ? pll_tick_q : mclk_tick; // RULE6
  // the lowest code is the slowest output, so the half period shrinks as the code grows
  assign out_last = 4'((clk_ctrl_pkg::CLKOUT_HALF_BASE
    << ~cs_q[clk_ctrl_pkg::CS_OUT_FREQ_LSB +: 2]) - clk_ctrl_pkg::ONE5); // RULE4 RULE18

  tick_divider #(.W(2)) u_core_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick_in(src_tick),
    .last(cs_q[clk_ctrl_pkg::CS_IN_FREQ_LSB +: 2]), // RULE8 RULE9
    .tick_out(core_tick)
  );

  tick_divider #(.W(4)) u_out_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick_in(src_tick & cs_q[clk_ctrl_pkg::CS_OUT_EN]),
    .last(out_last), // RULE18
    .tick_out(out_tick)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) clock_output_pin <= 1'b0;
    else if (!cs_q[clk_ctrl_pkg::CS_OUT_EN]) clock_output_pin <= 1'b0; // RULE5
    else if (out_tick) clock_output_pin <= ~clock_output_pin;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) core_clock_tick <= 1'b0;
    else core_clock_tick <= core_tick & cs_q[clk_ctrl_pkg::CS_CORE_EN]; // RULE11
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) core_supply_output <= clk_ctrl_pkg::SUP_RESET[clk_ctrl_pkg::SUP_LVL_LSB +: 2];
    else core_supply_output <= sup_q[clk_ctrl_pkg::SUP_LVL_LSB +: 2]; // RULE12
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: events set, writing one clears, set wins
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] w1c;

  always_comb begin
    ev = '0;
    ev[clk_ctrl_pkg::IRQ_LOCK] = lock_event;
    // pll chosen without declaring the 1024 fs input
    ev[clk_ctrl_pkg::IRQ_SRC_MISMATCH] = do_write && hit_cs && wstrb_q[0]
      && wdata_q[clk_ctrl_pkg::CS_SRC_SEL]
      && wdata_q[clk_ctrl_pkg::CS_IN_FREQ_LSB +: 2] != clk_ctrl_pkg::IN_FREQ_1024; // RULE7
  end

  assign w1c = (do_write && hit_st && wstrb_q[0]) ? wdata_q[IRQ_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) status_q <= '0;
    else status_q <= (status_q & ~w1c) | ev;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) mask_q <= '0;
    else if (do_write && hit_mk && wstrb_q[0]) mask_q <= wdata_q[IRQ_W-1:0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) irq <= 1'b0;
    else irq <= |(status_q & mask_q);
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_byte_write: assert property (do_write && hit_cs && wstrb_q[0] |=> // RULE1
    cs_q == ($past(wdata_q[7:0]) & clk_ctrl_pkg::CS_WMASK))
    else $error("clock_setup did not take the written byte");
  a_pll_atomic: assert property (do_write && hit_lo && !pll_commit |=> $stable(pll_q)) // RULE2
    else $error("pll parameters changed on a low word write");
  a_unmapped_err: assert property (do_write && !hit_any |=> bresp == clk_ctrl_pkg::RESP_SLVERR) // RULE3
    else $error("unmapped write not answered with slverr");
  a_out_disabled: assert property (!cs_q[clk_ctrl_pkg::CS_OUT_EN] |=> !clock_output_pin) // RULE5
    else $error("clock output toggles while disabled");
  a_core_gated: assert property (core_clock_tick |-> $past(cs_q[clk_ctrl_pkg::CS_CORE_EN])) // RULE11
    else $error("core tick while core clock gated");
  a_supply_follow: assert property (##1 core_supply_output == $past(sup_q[2:1], 1)) // RULE12
    else $error("supply level does not follow register");
  a_lock_sticky: assert property (lock_q && !pll_commit |=> lock_q) // RULE16
    else $error("lock indication dropped");
  a_pll_idle: assert property (!pll_en ##1 !pll_en |-> !pll_tick_q) // RULE15
    else $error("pll ticks while disabled");
  a_src_direct: assert property (!cs_q[clk_ctrl_pkg::CS_SRC_SEL] && pll_tick_q // RULE6
    && !mclk_tick |-> !src_tick)
    else $error("pll ticks reach the core in direct mode");
  a_irq_level: assert property (##1 irq == $past(|(status_q & mask_q))) // RULE7
    else $error("interrupt does not follow status and mask");

  c_lock: cover property (lock_event);
  c_clkout: cover property ($rose(clock_output_pin));
  c_mismatch: cover property (ev[clk_ctrl_pkg::IRQ_SRC_MISMATCH]);

endmodule // codec_clock_control

// ===== tb/mclk_source.sv
`timescale 1ns/100ps
////////////////////////////////////////
module mclk_source (
  // clock
  input wire logic aclk,
  // control from the bench
  input wire logic run,
  input wire logic [7:0] half,
  // master clock pin
  output logic pin
);
  logic [7:0] cnt_q;

  // stands low outside runs; half of 1 or more keeps the rate at or below aclk/2
  always_ff @(posedge aclk) begin
    if (!run) begin
      pin <= 1'b0;
      cnt_q <= 8'h00;
    end else if (cnt_q == half - 8'h01) begin
      pin <= ~pin;
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule // mclk_source

// ===== tb/testbench.sv
`timescale 1ns/100ps
////////////////////////////////////////
module testbench;
  localparam logic [31:0] A_CS = clk_ctrl_pkg::ADDR_CLOCK_SETUP;
  localparam logic [31:0] A_SUP = clk_ctrl_pkg::ADDR_CORE_SUPPLY;
  localparam logic [31:0] A_LO = clk_ctrl_pkg::ADDR_PLL_LO;
  localparam logic [31:0] A_HI = clk_ctrl_pkg::ADDR_PLL_HI;
  localparam logic [31:0] A_ST = clk_ctrl_pkg::ADDR_IRQ_STATUS;
  localparam logic [31:0] A_MK = clk_ctrl_pkg::ADDR_IRQ_MASK;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0000_0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] araddr = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, clk_out, tick, irq, mclk;
  logic [1:0] bresp, rresp, supply, rsp;
  logic [31:0] rdata, rd;
  logic run = 1'b0;
  logic [7:0] half = 8'h02;
  int error_cnt = 0;
  int checks = 0;
  int ct, co;

  always #2 aclk = ~aclk;

  codec_clock_control dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .master_clock_input_pin(mclk), .clock_output_pin(clk_out),
    .core_clock_tick(tick), .core_supply_output(supply), .irq(irq));

  mclk_source src (.aclk(aclk), .run(run), .half(half), .pin(mclk));

  ////////////////////////////////////////
  task automatic conclude();
    if (error_cnt == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // counts carry one tick of slack for the phase at the window edges
  task automatic near(input string nm, input int e, input int g);
    checks++;
    if (g < e - 1 || g > e + 1) begin
      error_cnt++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic hang();
    error_cnt++;
    $display("[FAIL] handshake expected done seen timeout");
    conclude();
  endtask

  task automatic axw(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
      n++;
      if (n > 100) hang();
    end
  endtask

  task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
      n++;
      if (n > 100) hang();
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    axw(a, d, rsp);
    chk("bresp", {30'h0, clk_ctrl_pkg::RESP_OKAY}, {30'h0, rsp});
  endtask

  task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
    axr(a, rd, rsp);
    chk(nm, e, rd);
  endtask

  task automatic settle();
    repeat (3) @(posedge aclk);
  endtask

  task automatic count(input int cyc);
    logic last;
    ct = 0;
    co = 0;
    last = clk_out;
    repeat (cyc) begin
      @(posedge aclk);
      if (tick === 1'b1) ct++;
      if (clk_out !== last) co++;
      last = clk_out;
    end
  endtask

  // commit, wait for lock through the interrupt, then run the core from the pll
  task automatic pll_run(input logic [31:0] lo, input logic [31:0] hi, input int e);
    int n;
    wr(A_LO, lo);
    wr(A_HI, hi);
    wr(A_ST, 32'h0000_0003);
    rdc("pll_lo", A_LO, lo);
    rdc("pll_hi", A_HI, hi);
    n = 0;
    while (irq !== 1'b1) begin
      @(posedge aclk);
      n++;
      if (n > 40000) hang();
    end
    rdc("pll_lo_locked", A_LO, lo | 32'h0000_0002);
    wr(A_ST, 32'h0000_0001);
    settle();
    chk("irq_cleared", 32'h0, {31'h0, irq});
    wr(A_CS, 32'h0000_000f);
    count(512);
    near("pll_core_ticks", e, ct);
  endtask

  ////////////////////////////////////////
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk("supply_pin", 32'h1, {30'h0, supply});
    chk("clkout_pin", 32'h0, {31'h0, clk_out});
    rdc("clock_setup", A_CS, 32'h0);
    rdc("core_supply", A_SUP, 32'h2);
    rdc("pll_lo", A_LO, 32'h0287_1901);
    rdc("pll_hi", A_HI, 32'h0000_0753);
    wr(A_CS, 32'hffff_ffff);
    rdc("clock_setup", A_CS, 32'h0000_007f);
    wr(A_SUP, 32'hffff_ffff);
    rdc("core_supply", A_SUP, 32'h0000_0006);
    settle();
    chk("supply_pin", 32'h3, {30'h0, supply});
    wr(A_SUP, 32'h0000_0000);
    settle();
    chk("supply_pin", 32'h0, {30'h0, supply});
    wr(A_CS, 32'h0000_0000);
    // the raw printed offset is not a bus address here
    axw(32'h0000_4000, 32'h0000_00ff, rsp);
    chk("bresp_unmapped", {30'h0, clk_ctrl_pkg::RESP_SLVERR}, {30'h0, rsp});
    axr(32'h0000_4000, rd, rsp);
    chk("rresp_unmapped", {30'h0, clk_ctrl_pkg::RESP_SLVERR}, {30'h0, rsp});
    chk("rdata_unmapped", 32'h0, rd);
    run <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(A_CS, 32'h0000_0011 | (32'(i) << 1) | (32'(i) << 5));
      count(384);
      near("core_ticks", 96 / (i + 1), ct);
      near("out_toggles", 6 << i, co);
    end
    wr(A_CS, 32'h0000_0000);
    count(384);
    near("core_ticks_off", 0, ct);
    near("out_toggles_off", 0, co);
    chk("clkout_pin", 32'h0, {31'h0, clk_out});
    wr(A_CS, 32'h0000_0008);
    axr(A_ST, rd, rsp);
    chk("status_mismatch", 32'h2, rd & 32'h0000_0002);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(A_MK, 32'h0000_0002);
    settle();
    chk("irq_raised", 32'h1, {31'h0, irq});
    wr(A_ST, 32'h0000_0002);
    settle();
    chk("irq_cleared", 32'h0, {31'h0, irq});
    wr(A_MK, 32'h0000_0001);
    half <= 8'h04;
    pll_run(32'h0000_2001, 32'h0000_0000, 64);
    pll_run(32'h0001_1301, 32'h0000_0002, 20);
    // pll switched off while it still feeds the core: the core must go quiet
    wr(A_LO, 32'h0000_2000);
    wr(A_HI, 32'h0000_0000);
    rdc("pll_lo_off", A_LO, 32'h0000_2000);
    count(256);
    near("pll_off_ticks", 0, ct);
    conclude();
  end
endmodule // testbench
